// [verilog/wit_pkg.sv]
// Purpose: shared constants and types of the watchdog / interval timer channel
// Assumes: one 100 MHz system clock; sub-clock arrives as a synchronous level input
// Notes:   register bit positions, write keys, reset values and pulse lengths live here

// ----------------------------------------------------------------------------
// package
// ----------------------------------------------------------------------------
package wit_pkg;

  // control/status bit positions
  localparam int WIT_BIT_OVF     = 7;    // overflow flag
  localparam int WIT_BIT_MODE    = 6;    // mode_select: 1 watchdog, 0 interval
  localparam int WIT_BIT_EN      = 5;    // count_enable
  localparam int WIT_BIT_PSS     = 4;    // prescaler_choice: 1 sub-clock
  localparam int WIT_BIT_RST     = 3;    // 1 internal reset, 0 nmi
  localparam int WIT_CKS_HI      = 2;    // clk_sel_bit2
  localparam int WIT_CKS_LO      = 0;    // clk_sel_bit0

  // reset values and counter limits
  localparam logic [7:0] WIT_CTRL_RESET  = 8'h00;
  localparam logic [7:0] WIT_CNT_RESET   = 8'h00;
  localparam logic [7:0] WIT_CNT_MAX     = 8'hFF;

  // write keys carried in the upper byte of a word write
  localparam logic [7:0] WIT_KEY_COUNTER = 8'h5A;
  localparam logic [7:0] WIT_KEY_CTRL    = 8'hA5;

  // read selects on the device bus
  localparam logic WIT_RADDR_CTRL    = 1'b0;
  localparam logic WIT_RADDR_COUNTER = 1'b1;

  // watchdog reset pulse lengths in system clocks
  localparam int WIT_INT_RESET_CLKS   = 518;
  localparam int WIT_RESET_OUT_STATES = 132;
  localparam int WIT_RC_W             = 10;

  // prescaler widths and divide exponents per clock select code
  localparam int WIT_MAIN_PS_W = 17;
  localparam int WIT_SUB_PS_W  = 8;
  localparam int WIT_MAIN_EXP [8] = '{1, 6, 7, 9, 11, 13, 15, 17};
  localparam int WIT_SUB_EXP  [8] = '{1, 2, 3, 4, 5, 6, 7, 8};

  // host user-port register map
  localparam logic [1:0] WIT_H_COUNTER = 2'h0;
  localparam logic [1:0] WIT_H_CTRL    = 2'h1;
  localparam logic [1:0] WIT_H_EVENTS  = 2'h2;
  localparam int WIT_EV_NMI       = 0;
  localparam int WIT_EV_IRQ       = 1;
  localparam int WIT_EV_INT_RESET = 2;
  localparam int WIT_EV_RESET_OUT = 3;
  localparam int WIT_EV_W         = 4;

  // watchdog reset pulse sequencer
  typedef enum logic [2:0] {
    WIT_ST_IDLE = 3'b001,    // no reset pending
    WIT_ST_BOTH = 3'b010,    // internal reset and reset-out pin active
    WIT_ST_INT  = 3'b100     // internal reset only
  } wit_rst_state_type;

endpackage : wit_pkg

// [verilog/wit_bus_if.sv]
// Purpose: carrier between the cpu-side controller and the timer channel
// Assumes: both ends run on the same clk; write strobes are one cycle long, the read strobe stays high while polling
// Notes:   read data stand only in the cycle after the read strobe

// ----------------------------------------------------------------------------
// interface
// ----------------------------------------------------------------------------
interface wit_bus_if;
  logic        wr;           // write strobe
  logic        wr_word;      // write is a 16-bit word transfer
  logic [15:0] wdata;        // key in upper byte, data in lower byte
  logic        rd;           // read strobe
  logic        raddr;        // 0 control/status, 1 counter
  logic [7:0]  rdata;        // read data, cycle after rd
  logic        int_reset;    // internal chip reset request
  logic        reset_out_n;  // reset-out pin level
  logic        nmi_req;      // non-maskable interrupt pulse
  logic        interval_irq; // interval interrupt level

  modport device (input wr, wr_word, wdata, rd, raddr,
                  output rdata, int_reset, reset_out_n, nmi_req, interval_irq);
  modport cpu    (output wr, wr_word, wdata, rd, raddr,
                  input rdata, int_reset, reset_out_n, nmi_req, interval_irq);
endinterface : wit_bus_if

// [verilog/wit_device.sv]
// Purpose: 8-bit watchdog / interval timer channel with main and sub-clock prescalers
// Assumes: sub_clk_in and ext_reset_n are synchronous to clk
// Notes:   word writes with key only; internal reset clears this channel's registers
//
// The register offsets and the strobed register port were left to the implementer.

// ----------------------------------------------------------------------------
// device end
// ----------------------------------------------------------------------------
module wit_device
  import wit_pkg::*;
#(
  parameter int INT_RESET_CLKS   = WIT_INT_RESET_CLKS,   // internal reset length
  parameter int RESET_OUT_STATES = WIT_RESET_OUT_STATES  // reset-out low length
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sub_clk_in,
  input  wire logic ext_reset_n,
  wit_bus_if.device bus,
  output logic      reset_source_flag
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (RESET_OUT_STATES < 1 || INT_RESET_CLKS <= RESET_OUT_STATES ||
      INT_RESET_CLKS > (1 << WIT_RC_W) - 1) begin : g_bad_len
    $error("reset pulse lengths out of range");
  end

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [6:0]               ctrl_r;        // control bits 6..0
  logic                     ovf_r;         // overflow_flag
  logic                     ovf_nxt;       // next overflow flag
  logic                     armed_r;       // flag was read as one
  logic [7:0]               cnt_r;         // wd_counter
  logic [WIT_MAIN_PS_W-1:0] main_ps_r;     // main_prescaler
  logic [WIT_SUB_PS_W-1:0]  sub_ps_r;      // sub-clock prescaler
  logic                     sub_prev_r;    // last sampled sub-clock level
  logic                     sub_edge;      // rising edge of sub-clock
  logic [7:0]               main_tap;      // main ticks per select code
  logic [7:0]               sub_tap;       // sub ticks per select code
  logic [2:0]               cks;           // clock select code
  logic                     tick;          // selected count pulse
  logic                     cnt_wr;        // keyed counter write
  logic                     ctrl_wr;       // keyed control write
  logic                     ovf_event;     // counter wraps this cycle
  logic                     wd_rst_ovf;    // overflow asks for chip reset
  wit_rst_state_type        rst_st_r;      // reset pulse sequencer
  logic [WIT_RC_W-1:0]      rc_r;          // reset pulse cycle count
  logic                     int_reset_r;   // internal reset output
  logic                     reset_out_n_r; // reset-out pin output
  logic                     nmi_r;         // nmi pulse output
  logic                     irq_r;         // interval irq output
  logic [7:0]               rdata_r;       // read data output
  logic                     src_r;         // reset_source_flag

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  // only word writes with the right key reach a register; none during reset
  assign cnt_wr  = bus.wr && bus.wr_word && !int_reset_r &&
                   bus.wdata[15:8] == WIT_KEY_COUNTER;
  assign ctrl_wr = bus.wr && bus.wr_word && !int_reset_r &&
                   bus.wdata[15:8] == WIT_KEY_CTRL;
  assign cks     = ctrl_r[WIT_CKS_HI:WIT_CKS_LO];

  // --------------------------------------------------------------------------
  // prescalers
  // --------------------------------------------------------------------------
  // main prescaler runs from clk and never stops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_ps_r <= '0;
    end else begin
      main_ps_r <= main_ps_r + 1'b1;
    end
  end

  // sub prescaler advances on each sub-clock rising edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sub_prev_r <= 1'b0;
      sub_ps_r   <= '0;
    end else begin
      sub_prev_r <= sub_clk_in;
      if (sub_edge) begin
        sub_ps_r <= sub_ps_r + 1'b1;
      end
    end
  end

  assign sub_edge = sub_clk_in && !sub_prev_r;

  // a tap fires once each 2**exp input clocks, when its low bits are all ones
  for (genvar i = 0; i < 8; i++) begin : g_tap
    assign main_tap[i] = &main_ps_r[WIT_MAIN_EXP[i]-1:0];
    assign sub_tap[i]  = sub_edge && (&sub_ps_r[WIT_SUB_EXP[i]-1:0]);
  end

  // prescaler choice picks the source, clock select picks the tap
  assign tick = ctrl_r[WIT_BIT_PSS] ? sub_tap[cks] : main_tap[cks];

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  assign ovf_event  = ctrl_r[WIT_BIT_EN] && tick && !cnt_wr &&
                      cnt_r == WIT_CNT_MAX;
  assign wd_rst_ovf = ovf_event && ctrl_r[WIT_BIT_MODE] && ctrl_r[WIT_BIT_RST];

  // write first, then stop-and-clear, then count
  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      cnt_r <= WIT_CNT_RESET;
    end else if (cnt_wr) begin
      cnt_r <= bus.wdata[7:0];
    end else if (!ctrl_r[WIT_BIT_EN]) begin
      cnt_r <= WIT_CNT_RESET;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // control bits
  // --------------------------------------------------------------------------
  // mode, enable, prescaler choice, action and clock select
  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      ctrl_r <= WIT_CTRL_RESET[6:0];
    end else if (ctrl_wr) begin
      ctrl_r <= bus.wdata[6:0];
    end
  end

  // --------------------------------------------------------------------------
  // overflow flag
  // --------------------------------------------------------------------------
  // clears first, a wrap in the same cycle wins over them
  always_comb begin
    ovf_nxt = ovf_r;
    if (ctrl_wr && armed_r && !bus.wdata[WIT_BIT_OVF]) begin
      ovf_nxt = 1'b0;
    end
    if (ctrl_wr && !bus.wdata[WIT_BIT_EN]) begin
      ovf_nxt = 1'b0;
    end
    if (ovf_event) begin
      ovf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      ovf_r <= WIT_CTRL_RESET[WIT_BIT_OVF];
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // read of control with flag at one arms the zero-write clear
  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      armed_r <= 1'b0;
    end else if (!ovf_nxt) begin
      armed_r <= 1'b0;
    end else if (bus.rd && bus.raddr == WIT_RADDR_CTRL && ovf_r) begin
      armed_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  // interval request follows the flag in interval mode
  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ovf_nxt && !ctrl_r[WIT_BIT_MODE];
    end
  end

  // one-cycle nmi pulse on watchdog overflow with nmi chosen
  always_ff @(posedge clk) begin
    if (!rst_n || int_reset_r) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= ovf_event && ctrl_r[WIT_BIT_MODE] && !ctrl_r[WIT_BIT_RST];
    end
  end

  // --------------------------------------------------------------------------
  // watchdog reset pulses
  // --------------------------------------------------------------------------
  // both outputs start together; reset-out ends first, internal reset later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_st_r      <= WIT_ST_IDLE;
      rc_r          <= '0;
      int_reset_r   <= 1'b0;
      reset_out_n_r <= 1'b1;
    end else begin
      case (rst_st_r)
        WIT_ST_IDLE: begin
          rc_r <= '0;
          if (wd_rst_ovf) begin
            rst_st_r      <= WIT_ST_BOTH;
            int_reset_r   <= 1'b1;
            reset_out_n_r <= 1'b0;
          end
        end
        WIT_ST_BOTH: begin
          rc_r <= rc_r + 1'b1;
          if (rc_r == WIT_RC_W'(RESET_OUT_STATES - 1)) begin
            rst_st_r      <= WIT_ST_INT;
            reset_out_n_r <= 1'b1;
          end
        end
        WIT_ST_INT: begin
          rc_r <= rc_r + 1'b1;
          if (rc_r == WIT_RC_W'(INT_RESET_CLKS - 1)) begin
            rst_st_r    <= WIT_ST_IDLE;
            int_reset_r <= 1'b0;
          end
        end
        default: begin
          rst_st_r      <= WIT_ST_IDLE;
          int_reset_r   <= 1'b0;
          reset_out_n_r <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // reset source
  // --------------------------------------------------------------------------
  // pin reset sets the flag and beats a coincident watchdog reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_r <= 1'b1;
    end else if (!ext_reset_n) begin
      src_r <= 1'b1;
    end else if (wd_rst_ovf) begin
      src_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n || !bus.rd) begin
      rdata_r <= 8'h00;
    end else if (bus.raddr == WIT_RADDR_CTRL) begin
      rdata_r <= {ovf_r, ctrl_r};
    end else begin
      rdata_r <= cnt_r;
    end
  end

  assign bus.rdata         = rdata_r;
  assign bus.int_reset     = int_reset_r;
  assign bus.reset_out_n   = reset_out_n_r;
  assign bus.nmi_req       = nmi_r;
  assign bus.interval_irq  = irq_r;
  assign reset_source_flag = src_r;

endmodule : wit_device

// [verilog/wit_host.sv]
// Purpose: cpu-side controller driving the timer channel from a plain register port
// Assumes: user strobes are one cycle, never both at once
// Notes:   polls both device registers continuously and serves counter and control reads from mirrors

// ----------------------------------------------------------------------------
// host end
// ----------------------------------------------------------------------------
module wit_host
  import wit_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] user_addr,
  input  wire logic [7:0] user_wdata,
  input  wire logic       user_wr,
  input  wire logic       user_rd,
  output logic      [7:0] user_rdata,
  wit_bus_if.cpu          bus
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic                wr_r;        // bus write strobe
  logic [15:0]         wdata_r;     // keyed bus write word
  logic                rd_r;        // bus read strobe
  logic                raddr_r;     // bus read select
  logic                rd_q_r;      // a poll went out last cycle
  logic                raddr_q_r;   // select of that poll
  logic [7:0]          ctrl_m_r;    // mirror of control/status
  logic [7:0]          cnt_m_r;     // mirror of counter
  logic [WIT_EV_W-1:0] ev_r;        // sticky event flags
  logic [WIT_EV_W-1:0] ev_in;       // events seen this cycle
  logic [7:0]          urdata_r;    // user read data

  // --------------------------------------------------------------------------
  // bus requests
  // --------------------------------------------------------------------------
  // a user counter or control write goes out next cycle, keyed; otherwise poll alternately
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r    <= 1'b0;
      wdata_r <= 16'h0000;
      rd_r    <= 1'b0;
      raddr_r <= WIT_RADDR_CTRL;
    end else if (user_wr && user_addr == WIT_H_COUNTER) begin
      wr_r    <= 1'b1;
      wdata_r <= {WIT_KEY_COUNTER, user_wdata};
      rd_r    <= 1'b0;
    end else if (user_wr && user_addr == WIT_H_CTRL) begin
      wr_r    <= 1'b1;
      wdata_r <= {WIT_KEY_CTRL, user_wdata};
      rd_r    <= 1'b0;
    end else begin
      wr_r    <= 1'b0;
      rd_r    <= 1'b1;
      raddr_r <= !raddr_r;
    end
  end

  // --------------------------------------------------------------------------
  // mirrors
  // --------------------------------------------------------------------------
  // delay strobe and select with the answer, since polls alternate every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q_r    <= 1'b0;
      raddr_q_r <= WIT_RADDR_CTRL;
    end else begin
      rd_q_r    <= rd_r;
      raddr_q_r <= raddr_r;
    end
  end

  // capture read data in the cycle after each poll
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_m_r <= WIT_CTRL_RESET;
      cnt_m_r  <= WIT_CNT_RESET;
    end else if (rd_q_r && raddr_q_r == WIT_RADDR_CTRL) begin
      ctrl_m_r <= bus.rdata;
    end else if (rd_q_r) begin
      cnt_m_r  <= bus.rdata;
    end
  end

  // --------------------------------------------------------------------------
  // events
  // --------------------------------------------------------------------------
  always_comb begin
    ev_in                   = '0;
    ev_in[WIT_EV_NMI]       = bus.nmi_req;
    ev_in[WIT_EV_IRQ]       = bus.interval_irq;
    ev_in[WIT_EV_INT_RESET] = bus.int_reset;
    ev_in[WIT_EV_RESET_OUT] = !bus.reset_out_n;
  end

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_r <= '0;
    end else if (user_wr && user_addr == WIT_H_EVENTS) begin
      ev_r <= (ev_r & ~user_wdata[WIT_EV_W-1:0]) | ev_in;
    end else begin
      ev_r <= ev_r | ev_in;
    end
  end

  // --------------------------------------------------------------------------
  // user read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !user_rd) begin
      urdata_r <= 8'h00;
    end else begin
      case (user_addr)
        WIT_H_COUNTER: urdata_r <= cnt_m_r;
        WIT_H_CTRL:    urdata_r <= ctrl_m_r;
        WIT_H_EVENTS:  urdata_r <= {{(8 - WIT_EV_W){1'b0}}, ev_r};
        default:       urdata_r <= 8'h00;
      endcase
    end
  end

  assign user_rdata = urdata_r;
  assign bus.wr      = wr_r;
  assign bus.wr_word = wr_r;
  assign bus.wdata   = wdata_r;
  assign bus.rd      = rd_r;
  assign bus.raddr   = raddr_r;

endmodule : wit_host

// [bench/wit_properties.sv]
// Purpose: checks pulse timing and read data on the host-device carrier
// Assumes: one clock; rst_n synchronous, active low
// Notes:   pulse lengths are counted in helper counters, not unrolled
// ---------------------------------------------------------------------------
// checker
// ---------------------------------------------------------------------------
module wit_properties
  import wit_pkg::*;
#(
  parameter int INT_RESET_CLKS   = WIT_INT_RESET_CLKS,   // internal reset length
  parameter int RESET_OUT_STATES = WIT_RESET_OUT_STATES  // reset-out low length
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       rd,
  input wire logic       raddr,
  input wire logic [7:0] rdata,
  input wire logic       int_reset,
  input wire logic       reset_out_n,
  input wire logic       nmi_req,
  input wire logic       interval_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] lo_cnt_r; // cycles reset-out has been low
  logic [9:0] hi_cnt_r; // cycles internal reset has been high
  // run lengths restart whenever the level ends
  always_ff @(posedge clk) lo_cnt_r <= (!rst_n || reset_out_n) ? 10'h000 : lo_cnt_r + 10'h001;
  always_ff @(posedge clk) hi_cnt_r <= (!rst_n || !int_reset) ? 10'h000 : hi_cnt_r + 10'h001;
  // control/status read and watchdog firing
  sequence ctrl_rd_s;
    rd && !raddr;
  endsequence
  sequence wd_fire_s;
    $rose(int_reset);
  endsequence
  idle_rdata_a: assert property (!rd |=> rdata == 8'h00) else $error("read data not idle");
  out_len_a: assert property ($rose(reset_out_n) |-> int'(lo_cnt_r) == RESET_OUT_STATES)
    else $error("reset-out low length wrong");
  int_len_a: assert property ($fell(int_reset) |-> int'(hi_cnt_r) == INT_RESET_CLKS)
    else $error("internal reset length wrong");
  pulse_pair_a: assert property (wd_fire_s |-> $fell(reset_out_n)) else $error("pin not low with reset");
  nmi_single_a: assert property (nmi_req |=> !nmi_req) else $error("nmi longer than one cycle");
  nmi_pin_a: assert property (nmi_req |-> reset_out_n && !int_reset) else $error("nmi with reset");
  irq_quiet_a: assert property (int_reset |-> !interval_irq) else $error("irq during watchdog reset");
  reset_clear_a: assert property (ctrl_rd_s ##0 (int_reset && $past(int_reset)) |=> rdata == 8'h00)
    else $error("control not cleared by reset");
  irq_flag_a: assert property (ctrl_rd_s ##0 interval_irq |=> rdata[7] && !rdata[6])
    else $error("irq without flag");
endmodule : wit_properties

// [bench/testbench.sv]
// Purpose: drives the host user port and judges the timer channel through it, plus the irq, reset-out and reset-source outputs directly
// Assumes: 100 MHz clk; short reset pulse lengths set by parameter
// Notes:   host mirrors lag the device, so writes are followed by a settle wait
// ---------------------------------------------------------------------------
// testbench
// ---------------------------------------------------------------------------
module testbench
  import wit_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IRC = 8; // shortened internal reset
  localparam int ROS = 3; // shortened reset-out low
  logic       clk = 1'b0;         // system clock
  logic       rst_n = 1'b0;       // reset, active low
  logic       sub_clk_in = 1'b0;  // sub-clock, still unless pulsed
  logic       ext_reset_n = 1'b1; // pin reset, active low
  logic [1:0] user_addr = 2'h0;
  logic [7:0] user_wdata = 8'h00;
  logic       user_wr = 1'b0;
  logic       user_rd = 1'b0;
  logic [7:0] user_rdata;
  logic       reset_source_flag;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         n;                  // cycles waited
  wit_bus_if  bus ();
  always #5 clk = ~clk;
  wit_device #(.INT_RESET_CLKS(IRC), .RESET_OUT_STATES(ROS)) wit_device_inst (.clk(clk), .rst_n(rst_n),
    .sub_clk_in(sub_clk_in), .ext_reset_n(ext_reset_n), .bus(bus), .reset_source_flag(reset_source_flag));
  wit_host wit_host_inst (.clk(clk), .rst_n(rst_n), .user_addr(user_addr), .user_wdata(user_wdata),
    .user_wr(user_wr), .user_rd(user_rd), .user_rdata(user_rdata), .bus(bus));
  wit_properties #(.INT_RESET_CLKS(IRC), .RESET_OUT_STATES(ROS)) wit_properties_inst (.clk(clk),
    .rst_n(rst_n), .rd(bus.rd), .raddr(bus.raddr), .rdata(bus.rdata), .int_reset(bus.int_reset),
    .reset_out_n(bus.reset_out_n), .nmi_req(bus.nmi_req), .interval_irq(bus.interval_irq));
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // one-cycle write, then let the host mirrors settle
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    user_addr <= a;
    user_wdata <= d;
    user_wr <= 1'b1;
    @(posedge clk);
    user_wr <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : wr_reg
  // one-cycle read; data stand in the next cycle and are judged at its closing edge
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
    user_addr <= a;
    user_rd <= 1'b1;
    @(posedge clk);
    user_rd <= 1'b0;
    @(posedge clk);
    check(what, user_rdata, exp);
  endtask : rd_chk
  // 0 irq, 1 nmi, 2 reset high, 3 reset low
  function automatic logic ev(input int k);
    return k == 0 ? bus.interval_irq : k == 1 ? bus.nmi_req : k == 2 ? bus.int_reset : !bus.int_reset;
  endfunction : ev
  task automatic wait_ev(input int k, input int lim);
    n = 0;
    while (ev(k) !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        check("event wait", 8'h00, 8'h01);
        stop_test();
      end
    end
  endtask : wait_ev
  task automatic sub_edges(input int k);
    repeat (2 * k) begin
      repeat (4) @(posedge clk);
      sub_clk_in <= ~sub_clk_in;
    end
    repeat (4) @(posedge clk);
  endtask : sub_edges
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(WIT_H_CTRL, 8'h00, "ctrl reset");
    rd_chk(WIT_H_COUNTER, 8'h00, "count reset");
    check("source reset", {7'h00, reset_source_flag}, 8'h01);
    $display("reset test done");
  endtask : t_reset
  // interval overflow for main divider codes 0 to 4, then clear by zero write or disable
  task automatic t_main();
    for (logic [7:0] c = 8'h00; c < 8'h05; c++) begin
      wr_reg(WIT_H_CTRL, 8'h20 | c);
      wr_reg(WIT_H_COUNTER, 8'hFE);
      wait_ev(0, 2 ** (WIT_MAIN_EXP[c] + 1) + 8);
      check("ovf time", 8'(n >= 2 ** WIT_MAIN_EXP[c] - 8), 8'h01);
      repeat (6) @(posedge clk);
      rd_chk(WIT_H_CTRL, 8'hA0 | c, "ctrl ovf");
      wr_reg(WIT_H_CTRL, c[0] ? 8'h20 | c : 8'h80);
      rd_chk(WIT_H_CTRL, c[0] ? 8'h20 | c : 8'h00, "ctrl clear");
      wr_reg(WIT_H_CTRL, 8'h00);
      rd_chk(WIT_H_COUNTER, 8'h00, "count off");
    end
    $display("main prescaler test done");
  endtask : t_main
  task automatic t_sub();
    wr_reg(WIT_H_CTRL, 8'h30);
    wr_reg(WIT_H_COUNTER, 8'hFE);
    repeat (20) @(posedge clk);
    check("sub idle", {7'h00, bus.interval_irq}, 8'h00);
    sub_edges(2);
    check("sub one tick", {7'h00, bus.interval_irq}, 8'h00);
    sub_edges(2);
    check("sub two ticks", {7'h00, bus.interval_irq}, 8'h01);
    wr_reg(WIT_H_CTRL, 8'h00);
    $display("sub prescaler test done");
  endtask : t_sub
  task automatic t_nmi();
    wr_reg(WIT_H_EVENTS, 8'h0F);
    wr_reg(WIT_H_CTRL, 8'h61);
    wr_reg(WIT_H_COUNTER, 8'hFE);
    wait_ev(1, 160);
    check("pin high", {7'h00, bus.reset_out_n}, 8'h01);
    repeat (6) @(posedge clk);
    rd_chk(WIT_H_EVENTS, 8'h01, "events nmi");
    wr_reg(WIT_H_CTRL, 8'h00);
    $display("nmi test done");
  endtask : t_nmi
  task automatic t_wdrst();
    wr_reg(WIT_H_EVENTS, 8'h0F);
    wr_reg(WIT_H_CTRL, 8'h69);
    wr_reg(WIT_H_COUNTER, 8'hFE);
    wait_ev(2, 160);
    check("source wd", {7'h00, reset_source_flag}, 8'h00);
    wr_reg(WIT_H_COUNTER, 8'h77);
    wait_ev(3, 16);
    repeat (6) @(posedge clk);
    rd_chk(WIT_H_CTRL, 8'h00, "ctrl after wd");
    rd_chk(WIT_H_COUNTER, 8'h00, "count after wd");
    rd_chk(WIT_H_EVENTS, 8'h0C, "events wd");
    ext_reset_n <= 1'b0;
    @(posedge clk);
    ext_reset_n <= 1'b1;
    @(posedge clk);
    check("source pin", {7'h00, reset_source_flag}, 8'h01);
    $display("watchdog reset test done");
  endtask : t_wdrst
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_main();
    t_sub();
    t_nmi();
    t_wdrst();
    stop_test();
  end
endmodule : testbench
